// File: hdl/indicator_pkg.sv
// constants for the status indicator block
// assumes a 16-bit management register port with word-wide write strobes
`default_nettype none
package indicator_pkg;
  localparam logic [4:0] INDICATOR_CONTROL_ADDR = 5'h18;
  localparam logic [4:0] PHY_CONTROL_ADDR = 5'h19;
  // indicator control fields
  localparam int ACT_RX_ONLY_BIT = 8;
  localparam int FLASH_RATE_HI = 7;
  localparam int FLASH_RATE_LO = 6;
  localparam int OVR_EN_LINK_BIT = 5;
  localparam int OVR_EN_SPEED_BIT = 4;
  localparam int OVR_EN_ACT_BIT = 3;
  localparam int OVR_VAL_LINK_BIT = 2;
  localparam int OVR_VAL_SPEED_BIT = 1;
  localparam int OVR_VAL_ACT_BIT = 0;
  localparam logic [15:0] INDICATOR_CONTROL_RESET = 16'h0000;
  // phy control fields
  localparam int MODE_HI_BIT = 6;
  localparam int MODE_LO_BIT = 5;
  localparam logic [15:0] PHY_CONTROL_RESET = 16'h0020;
  localparam logic [15:0] PHY_CONTROL_WMASK = 16'h0060;
  localparam logic [15:0] INDICATOR_CONTROL_WMASK = 16'h01FF;
  // timing at 20 MHz
  localparam int CLK_PERIOD_NS = 50;
  localparam int STRETCH_MS = 50;
  localparam int STRETCH_CYCLES = (STRETCH_MS * 1000000) / CLK_PERIOD_NS;
  localparam int FLASH_BASE_MS = 50;
  localparam int FLASH_BASE_CYCLES = (FLASH_BASE_MS * 1000000) / CLK_PERIOD_NS;
  localparam int LINK_PULSES_NEEDED = 7;
  typedef enum logic [2:0]
  {
    MODE_ONE = 3'b001,
    MODE_TWO = 3'b010,
    MODE_THREE = 3'b100
  } mode_type;
endpackage
`default_nettype wire

// File: hdl/indicator_if.sv
// carries status between the timing helper and the top
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
interface indicator_if;
  logic flash_tick;
  logic [1:0] flash_rate;
  logic act_event;
  logic act_stretched;
  modport timer (input flash_rate, input act_event, output flash_tick, output act_stretched);
  modport top (output flash_rate, output act_event, input flash_tick, input act_stretched);
endinterface
`default_nettype wire

// File: hdl/indicator_timer.sv
// flash tick divider and activity stretcher
// assumes synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module indicator_timer
#(
  parameter int STRETCH = indicator_pkg::STRETCH_CYCLES,
  parameter int FLASH_BASE = indicator_pkg::FLASH_BASE_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  indicator_if.timer bus
);
  import indicator_pkg::*;
  logic [31:0] div_r, div_nxt;
  logic [31:0] str_r, str_nxt;
  logic tick_r, tick_nxt;
  logic [31:0] limit;

  always_comb
  begin
    // base period scaled by 1, 2, 4 or 8
    limit = (FLASH_BASE << bus.flash_rate) - 1;
    tick_nxt = 1'b0;
    div_nxt = div_r + 32'h00000001;
    if (div_r >= limit)
    begin
      div_nxt = 32'h00000000;
      tick_nxt = 1'b1;
    end
    str_nxt = str_r;
    if (bus.act_event)
      str_nxt = STRETCH;
    else if (str_r != 32'h00000000)
      str_nxt = str_r - 32'h00000001;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      div_r <= 32'h00000000;
      str_r <= 32'h00000000;
      tick_r <= 1'b0;
    end
    else
    begin
      div_r <= div_nxt;
      str_r <= str_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign bus.flash_tick = tick_r;
  assign bus.act_stretched = (str_r != 32'h00000000);
endmodule
`default_nettype wire

// File: hdl/status_indicator_outputs.sv
// status indicator outputs: link, speed and activity lamps
// assumes status inputs synchronous to CLK_IN; straps valid while reset is held
//
// Notes on behaviour
// - three outputs: link, speed and activity, function set by mode.
// - mode is the two-bit field at bits 6:5 of phy control 19h.
// - upper mode bit only set by register write, never by strap.
// - low bit set is mode 1; 00 is mode 2; 10 is mode 3.
// - mode 1 link output on for good link, off without link.
// - 100 Mb/s link declared from signal detect indication.
// - 10 Mb/s link after seven consecutive link pulses or a valid packet.
// - link drops on loss timer, or about 1.3 us with fast loss enabled.
// - modes 2 and 3: link steady on when good, blinks with activity.
// - blink rate from bits 7:6 of indicator control 18h.
// - bit 8 of 18h: 0 transmit or receive activity, 1 receive only.
// - speed output high at 100 Mb/s, low at 10 Mb/s, any mode.
// - mode 1 activity output on during transmit or receive activity.
// - mode 2 activity output shows collision.
// - mode 3 activity output on for full duplex, off for half.
// - 10 Mb/s half duplex collision comes from the MII COL signal.
// - strap low gives active-high output, strap high gives active-low.
// - software may drive any indicator output directly through 18h.
// - reading 18h does not return the actual output levels.
`timescale 1ns/1ps
`default_nettype none
module status_indicator_outputs
#(
  parameter int STRETCH = indicator_pkg::STRETCH_CYCLES,
  parameter int FLASH_BASE = indicator_pkg::FLASH_BASE_CYCLES
)
(
  // clock and reset
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  // management register port
  input wire logic [4:0] REG_ADDR_IN,
  input wire logic [15:0] REG_WDATA_IN,
  input wire logic REG_WRITE_IN,
  output logic [15:0] REG_RDATA_OUT,
  // line status
  input wire logic SPEED_100_IN,
  input wire logic FULL_DUPLEX_IN,
  input wire logic SIGNAL_DETECT_IN,
  input wire logic LINK_PULSE_IN,
  input wire logic LINK_PULSE_LOST_IN,
  input wire logic VALID_PACKET_10_IN,
  input wire logic LINK_LOSS_TIMER_IN,
  input wire logic FAST_LOSS_ENABLE_IN,
  input wire logic TX_ACTIVE_IN,
  input wire logic RX_ACTIVE_IN,
  input wire logic COL_IN,
  // strap levels on the indicator pins
  input wire logic [2:0] NEGOTIATION_STRAP_IN,
  // indicator pins: link, speed, activity
  output logic LINK_INDICATOR_OUT,
  output logic SPEED_INDICATOR_OUT,
  output logic ACTIVITY_INDICATOR_OUT
);
  import indicator_pkg::*;

  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [15:0] ictl_r, ictl_nxt;
  logic [15:0] pctl_r, pctl_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic [2:0] pol_r, pol_nxt;
  logic rst_d_r;
  mode_type mode;

  always_comb
  begin
    ictl_nxt = ictl_r;
    pctl_nxt = pctl_r;
    if (REG_WRITE_IN && REG_ADDR_IN == INDICATOR_CONTROL_ADDR)
      ictl_nxt = REG_WDATA_IN & INDICATOR_CONTROL_WMASK;
    if (REG_WRITE_IN && REG_ADDR_IN == PHY_CONTROL_ADDR)
      pctl_nxt = REG_WDATA_IN & PHY_CONTROL_WMASK;
    // register contents only, never the pin levels
    case (REG_ADDR_IN)
      INDICATOR_CONTROL_ADDR: rdata_nxt = ictl_r;
      PHY_CONTROL_ADDR: rdata_nxt = pctl_r;
      default: rdata_nxt = 16'h0000;
    endcase
    // strap captured while the delayed reset rst_d_r is high, up to one cycle after reset release
    pol_nxt = pol_r;
    if (rst_d_r)
      pol_nxt = NEGOTIATION_STRAP_IN;
  end

  always_ff @(posedge CLK_IN)
  begin
    rst_d_r <= SYS_RST_IN;
    pol_r <= pol_nxt;
    if (SYS_RST_IN)
    begin
      ictl_r <= INDICATOR_CONTROL_RESET;
      pctl_r <= PHY_CONTROL_RESET;
      rdata_r <= 16'h0000;
    end
    else
    begin
      ictl_r <= ictl_nxt;
      pctl_r <= pctl_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  always_comb
  begin
    if (pctl_r[MODE_LO_BIT])
      mode = MODE_ONE;
    else if (pctl_r[MODE_HI_BIT])
      mode = MODE_THREE;
    else
      mode = MODE_TWO;
  end

  // ----------------------------------------
  // link detection
  // ----------------------------------------
  logic [2:0] pulse_cnt_r, pulse_cnt_nxt;
  logic link10_r, link10_nxt;
  logic link_good;

  always_comb
  begin
    pulse_cnt_nxt = pulse_cnt_r;
    link10_nxt = link10_r;
    if (SPEED_100_IN || LINK_PULSE_LOST_IN)
      pulse_cnt_nxt = 3'h0;
    else if (LINK_PULSE_IN && pulse_cnt_r != 3'(LINK_PULSES_NEEDED))
      pulse_cnt_nxt = pulse_cnt_r + 3'h1;
    if (SPEED_100_IN || LINK_LOSS_TIMER_IN)
      link10_nxt = 1'b0;
    if (!SPEED_100_IN && (VALID_PACKET_10_IN ||
        (LINK_PULSE_IN && pulse_cnt_r == 3'(LINK_PULSES_NEEDED - 1))))
      link10_nxt = 1'b1;
  end

  always_ff @(posedge CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      pulse_cnt_r <= 3'h0;
      link10_r <= 1'b0;
    end
    else
    begin
      pulse_cnt_r <= pulse_cnt_nxt;
      link10_r <= link10_nxt;
    end
  end

  // 100 Mb/s: signal detect; its loss timing (standard or fast) lives in the
  // receiver, selected there by FAST_LOSS_ENABLE_IN
  assign link_good = SPEED_100_IN ? SIGNAL_DETECT_IN : link10_r;

  // ----------------------------------------
  // activity, blink and output
  // ----------------------------------------
  indicator_if tif();
  indicator_timer #(.STRETCH(STRETCH), .FLASH_BASE(FLASH_BASE)) timer_u
  (
    .clk(CLK_IN),
    .rst(SYS_RST_IN),
    .bus(tif.timer)
  );

  logic act_raw;
  assign act_raw = ictl_r[ACT_RX_ONLY_BIT] ? RX_ACTIVE_IN
                                           : (RX_ACTIVE_IN | TX_ACTIVE_IN);
  assign tif.act_event = act_raw;
  assign tif.flash_rate = ictl_r[FLASH_RATE_HI:FLASH_RATE_LO];

  logic blink_r, blink_nxt;
  logic [2:0] pins_r, pins_nxt;
  logic [2:0] state;
  logic collision;

  // collision only meaningful in half duplex; 10 Mb/s half duplex uses COL
  assign collision = COL_IN & ~FULL_DUPLEX_IN;

  always_comb
  begin
    blink_nxt = blink_r;
    if (tif.flash_tick)
      blink_nxt = ~blink_r;
    state[1] = SPEED_100_IN;
    case (mode)
      MODE_ONE:
      begin
        state[2] = link_good;
        state[0] = tif.act_stretched;
      end
      MODE_TWO:
      begin
        state[2] = link_good & ~(tif.act_stretched & blink_r);
        state[0] = collision;
      end
      MODE_THREE:
      begin
        state[2] = link_good & ~(tif.act_stretched & blink_r);
        state[0] = FULL_DUPLEX_IN;
      end
      default:
      begin
        state[2] = 1'b0;
        state[0] = 1'b0;
      end
    endcase
    if (ictl_r[OVR_EN_LINK_BIT])
      state[2] = ictl_r[OVR_VAL_LINK_BIT];
    if (ictl_r[OVR_EN_SPEED_BIT])
      state[1] = ictl_r[OVR_VAL_SPEED_BIT];
    if (ictl_r[OVR_EN_ACT_BIT])
      state[0] = ictl_r[OVR_VAL_ACT_BIT];
    pins_nxt = state ^ pol_r;
  end

  always_ff @(posedge CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      blink_r <= 1'b0;
      pins_r <= 3'h0;
    end
    else
    begin
      blink_r <= blink_nxt;
      pins_r <= pins_nxt;
    end
  end

  assign REG_RDATA_OUT = rdata_r;
  assign LINK_INDICATOR_OUT = pins_r[2];
  assign SPEED_INDICATOR_OUT = pins_r[1];
  assign ACTIVITY_INDICATOR_OUT = pins_r[0];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // pins show the state of the cycle before, through the sampled polarity
  speed_follow_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    !ictl_r[OVR_EN_SPEED_BIT] |=>
      (SPEED_INDICATOR_OUT == ($past(SPEED_100_IN) ^ pol_r[1])))
    else $error("speed output does not follow rate");
  mode1_link_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (mode == MODE_ONE && !ictl_r[OVR_EN_LINK_BIT]) |=>
      (LINK_INDICATOR_OUT == ($past(link_good) ^ pol_r[2])))
    else $error("mode 1 link output wrong");
  detect_link_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (SPEED_100_IN && mode == MODE_ONE && !ictl_r[OVR_EN_LINK_BIT]) |=>
      (LINK_INDICATOR_OUT == ($past(SIGNAL_DETECT_IN) ^ pol_r[2])))
    else $error("signal detect not shown as link");
  steady_link_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (mode != MODE_ONE && !ictl_r[OVR_EN_LINK_BIT] && !tif.act_stretched) |=>
      (LINK_INDICATOR_OUT == ($past(link_good) ^ pol_r[2])))
    else $error("link not steady without activity");
  link_blank_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (mode != MODE_ONE && !ictl_r[OVR_EN_LINK_BIT] && tif.act_stretched && blink_r) |=>
      (LINK_INDICATOR_OUT == pol_r[2]))
    else $error("link not blanked in blink phase");
  act_show_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (mode == MODE_ONE && !ictl_r[OVR_EN_ACT_BIT]) |=>
      (ACTIVITY_INDICATOR_OUT == ($past(tif.act_stretched) ^ pol_r[0])))
    else $error("activity not shown in mode 1");
  collision_show_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (mode == MODE_TWO && !ictl_r[OVR_EN_ACT_BIT]) |=>
      (ACTIVITY_INDICATOR_OUT == (($past(COL_IN) & ~$past(FULL_DUPLEX_IN)) ^ pol_r[0])))
    else $error("collision not shown in mode 2");
  duplex_show_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (mode == MODE_THREE && !ictl_r[OVR_EN_ACT_BIT]) |=>
      (ACTIVITY_INDICATOR_OUT == ($past(FULL_DUPLEX_IN) ^ pol_r[0])))
    else $error("duplex not shown");
  override_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    ictl_r[OVR_EN_LINK_BIT] |=>
      (LINK_INDICATOR_OUT == ($past(ictl_r[OVR_VAL_LINK_BIT]) ^ pol_r[2])))
    else $error("link override ignored");
  // register side
  mode_decode_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    pctl_r[MODE_LO_BIT] |-> mode == MODE_ONE)
    else $error("mode decode wrong");
  phy_write_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (REG_WRITE_IN && REG_ADDR_IN == PHY_CONTROL_ADDR) |=>
      (pctl_r == ($past(REG_WDATA_IN) & PHY_CONTROL_WMASK)))
    else $error("phy control write not taken");
  read_back_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (REG_ADDR_IN == INDICATOR_CONTROL_ADDR) |=> (REG_RDATA_OUT == $past(ictl_r)))
    else $error("indicator control read not register contents");
  rx_only_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (ictl_r[ACT_RX_ONLY_BIT] && TX_ACTIVE_IN && !RX_ACTIVE_IN) |-> !tif.act_event)
    else $error("transmit counted in receive-only");
  // link, strap and activity stretch state
  link10_set_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (!SPEED_100_IN && VALID_PACKET_10_IN) |=> link10_r)
    else $error("valid packet did not raise link");
  link10_drop_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (SPEED_100_IN || (LINK_LOSS_TIMER_IN && !VALID_PACKET_10_IN && !LINK_PULSE_IN)) |=>
      !link10_r)
    else $error("10 Mb/s link not dropped");
  strap_take_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (rst_d_r && !SYS_RST_IN) |=> (pol_r == $past(NEGOTIATION_STRAP_IN)))
    else $error("strap level not captured at reset");
  strap_hold_a: assert property (@(posedge CLK_IN)
    (!rst_d_r && !SYS_RST_IN) |=> $stable(pol_r))
    else $error("polarity changed outside reset");
  stretch_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    act_raw |=> tif.act_stretched[*2])
    else $error("activity not stretched");
endmodule
`default_nettype wire

// File: testbench/lamp_model.sv
// lamps and strap resistors on the three indicator pins
// assumes pull levels change only while reset is held
`timescale 1ns/1ps
`default_nettype none
module lamp_model
(
  // resistor wiring and pin levels, order link, speed, activity
  input wire logic [2:0] pull,
  input wire logic [2:0] pins,
  // strap level seen by the device and lamp state
  output logic [2:0] strap,
  output logic [2:0] lit
);
  assign strap = pull;
  // a pulled-up pin sinks the lamp current, so it is lit when low
  assign lit = pins ^ pull;
endmodule
`default_nettype wire

// File: testbench/test_status_indicator_outputs.sv
// self-checking bench for the status indicator block
// assumes lamp_model on the pins and short timer parameters
`timescale 1ns/1ps
`default_nettype none
module test_status_indicator_outputs;
  import indicator_pkg::*;
  localparam int STRETCH = 4;
  localparam int FLASH_BASE = 3;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [4:0] addr = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'h0;
  logic spd = 1'h0, fdx = 1'h0, sd = 1'h0, lp = 1'h0, lpl = 1'h0;
  logic vp = 1'h0, llt = 1'h0, fle = 1'h0, tx = 1'h0, rx = 1'h0, col = 1'h0;
  logic [2:0] pull = 3'h5;
  wire [15:0] rdata;
  wire [2:0] pins;
  wire [2:0] strap;
  wire [2:0] lit;
  int n_mismatch = 0;
  int compares = 0;
  int cnt [4];
  int n;

  status_indicator_outputs #(.STRETCH(STRETCH), .FLASH_BASE(FLASH_BASE)) dut
  (
    .CLK_IN(clk), .SYS_RST_IN(rst),
    .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WRITE_IN(wr), .REG_RDATA_OUT(rdata),
    .SPEED_100_IN(spd), .FULL_DUPLEX_IN(fdx), .SIGNAL_DETECT_IN(sd),
    .LINK_PULSE_IN(lp), .LINK_PULSE_LOST_IN(lpl), .VALID_PACKET_10_IN(vp),
    .LINK_LOSS_TIMER_IN(llt), .FAST_LOSS_ENABLE_IN(fle),
    .TX_ACTIVE_IN(tx), .RX_ACTIVE_IN(rx), .COL_IN(col),
    .NEGOTIATION_STRAP_IN(strap),
    .LINK_INDICATOR_OUT(pins[2]), .SPEED_INDICATOR_OUT(pins[1]),
    .ACTIVITY_INDICATOR_OUT(pins[0])
  );
  lamp_model lamps (.pull(pull), .pins(pins), .strap(strap), .lit(lit));

  initial forever #25 clk = ~clk;

  // ----------------------------------------
  // access and compare tasks
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic settle(input int c);
    repeat (c) @(negedge clk);
  endtask
  task automatic lamp(input string w, input logic [2:0] e);
    settle(3);
    chk(w, {13'h0000, e}, {13'h0000, lit});
  endtask
  task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'h1;
    @(negedge clk);
    wr = 1'h0;
  endtask
  task automatic reg_read(input logic [4:0] a, input logic [15:0] e);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    chk($sformatf("reg_%h", a), e, rdata);
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    @(negedge clk);
    s = 1'h0;
    @(negedge clk);
  endtask
  task automatic do_reset(input logic [2:0] p);
    rst = 1'h1;
    pull = p;
    settle(3);
    rst = 1'h0;
    settle(2);
  endtask
  // counts link lamp toggles over a fixed window
  task automatic flashes(input logic [15:0] ctl, output int t);
    logic last;
    reg_write(INDICATOR_CONTROL_ADDR, ctl);
    settle(STRETCH + 6);
    t = 0;
    last = lit[2];
    repeat (96)
    begin
      @(negedge clk);
      if (lit[2] !== last)
        t++;
      last = lit[2];
    end
  endtask

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial
  begin
    do_reset(3'h5);
    reg_read(INDICATOR_CONTROL_ADDR, INDICATOR_CONTROL_RESET);
    reg_read(PHY_CONTROL_ADDR, 16'h0020);
    reg_read(5'h00, 16'h0000);
    reg_write(PHY_CONTROL_ADDR, 16'hFFFF);
    reg_read(PHY_CONTROL_ADDR, 16'h0060);
    sd = 1'h1;
    spd = 1'h1;
    lamp("mode1 link", 3'h6);
    pulse(tx);
    lamp("stretched act", 3'h7);
    settle(STRETCH + 3);
    lamp("act idle", 3'h6);
    reg_write(INDICATOR_CONTROL_ADDR, 16'h0038);
    lamp("override off", 3'h0);
    reg_read(INDICATOR_CONTROL_ADDR, 16'h0038);
    reg_write(INDICATOR_CONTROL_ADDR, 16'hFFFF);
    lamp("override on", 3'h7);
    reg_read(INDICATOR_CONTROL_ADDR, 16'h01FF);
    reg_write(INDICATOR_CONTROL_ADDR, 16'h0000);
    spd = 1'h0;
    sd = 1'h0;
    pulse(llt);
    repeat (6) pulse(lp);
    pulse(lpl);
    repeat (6) pulse(lp);
    lamp("six pulses", 3'h0);
    pulse(lp);
    lamp("seven pulses", 3'h4);
    pulse(llt);
    lamp("loss timer", 3'h0);
    pulse(vp);
    lamp("valid packet", 3'h4);
    reg_write(PHY_CONTROL_ADDR, 16'h0000);
    col = 1'h1;
    lamp("collision", 3'h5);
    col = 1'h0;
    lamp("no collision", 3'h4);
    rx = 1'h1;
    for (int r = 0; r < 4; r++)
    begin
      flashes({8'h00, r[1:0], 6'h00}, cnt[r]);
      chk("flash seen", 16'h0001, {15'h0000, cnt[r] > 0});
      if (r > 0)
        chk("flash slower", 16'h0001, {15'h0000, cnt[r - 1] > cnt[r]});
    end
    rx = 1'h0;
    tx = 1'h1;
    flashes(16'h0100, n);
    chk("rx only flash", 16'h0000, n[15:0]);
    tx = 1'h0;
    reg_write(INDICATOR_CONTROL_ADDR, 16'h0000);
    reg_write(PHY_CONTROL_ADDR, 16'h0040);
    settle(STRETCH + 6);
    fdx = 1'h1;
    spd = 1'h1;
    sd = 1'h1;
    lamp("full duplex", 3'h7);
    fdx = 1'h0;
    lamp("half duplex", 3'h6);
    do_reset(3'h2);
    lamp("strap flipped", 3'h6);
    // strap level moves outside reset: the pin levels must not follow it
    pull = 3'h7;
    settle(3);
    chk("strap ignored", {13'h0000, 3'h4}, {13'h0000, pins});
    tally_and_finish;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
